// file: fsg_flash_guard.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsg_defs.svh"

module fsg_flash_guard #(
  parameter bit BIG_ARRAY = 1'b1,
  parameter int unsigned TW_CYCLES = `FSG_TW_CYCLES
) (
  // System clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Serial link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic io0_in,
  output logic io1_out,
  output logic io1_oe_out,
  input wire logic io2_in,
  input wire logic io3_in,
  // Non-volatile storage
  input wire logic [7:0] nv_bits_in,
  output logic [7:0] nv_bits_out,
  output logic nv_store_out,
  // Array engine
  output logic op_start_out,
  output fsg_pkg::fsg_op_t op_kind_out,
  output logic [23:0] op_addr_out,
  output logic op_suspend_out,
  input wire logic array_done_in,
  // Status view
  output logic [15:0] status_out,
  output logic quad_mode_out
);

  function automatic fsg_pkg::fsg_region_t guard_region(
    input logic [4:0] bp,
    input logic inv,
    input logic big
  );
    logic [23:0] top;
    logic [23:0] sz;
    logic none;
    logic all;
    fsg_pkg::fsg_region_t r;
    top = big ? `FSG_TOP_4M : `FSG_TOP_2M;
    sz = `FSG_RST_ADDR;
    none = 1'b0;
    all = 1'b0;
    if (!bp[4]) begin
      if (big && bp[2]) begin
        all = 1'b1;
      end else if (bp[1:0] == 2'b00) begin
        none = 1'b1;
      end else if (!big && bp[1:0] == 2'b11) begin
        all = 1'b1;
      end else begin
        sz = `FSG_BLOCK_64K << (bp[1:0] - 2'd1);
      end
    end else begin
      if (bp[2:0] == 3'b000) begin
        none = 1'b1;
      end else if (bp[2:0] == 3'b111) begin
        all = 1'b1;
      end else if (bp[2]) begin
        sz = `FSG_SECT_4K << 3;
      end else begin
        sz = `FSG_SECT_4K << (bp[1:0] - 2'd1);
      end
    end
    // Inverting swaps none/all and takes the far side of the boundary
    if (inv) begin
      r.en = !all;
      if (none) begin
        r.lo = `FSG_RST_ADDR;
        r.hi = top;
      end else if (bp[3]) begin
        r.lo = sz;
        r.hi = top;
      end else begin
        r.lo = `FSG_RST_ADDR;
        r.hi = top - sz;
      end
    end else begin
      r.en = !none;
      if (all) begin
        r.lo = `FSG_RST_ADDR;
        r.hi = top;
      end else if (bp[3]) begin
        r.lo = `FSG_RST_ADDR;
        r.hi = sz - 24'h000001;
      end else begin
        r.lo = top - sz + 24'h000001;
        r.hi = top;
      end
    end
    return r;
  endfunction

  // Link domain: serial clock, frames bounded by chip select
  logic link_rst;
  logic active_q;
  logic [2:0] bit_q;
  logic [2:0] bytes_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [7:0] b3_q;
  logic so_q;
  logic so_oe_q;
  logic shift_en;
  logic [7:0] in_byte;
  logic [7:0] rd_byte;
  logic rd_cmd;

  // System domain
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic frame_end;
  logic [15:0] snap_q;
  logic [15:0] status_word;
  fsg_pkg::fsg_state_t state_q;
  logic [31:0] tw_cnt_q;
  logic arm_q;
  logic [4:0] guard_q;
  logic lock_q;
  logic quad_q;
  logic inv_q;
  logic loaded_q;
  logic busy;
  logic wp_eff;
  logic stat_locked;
  logic aligned;
  logic [23:0] addr_m;
  logic [23:0] range_mask;
  logic [23:0] rstart;
  logic [23:0] rend;
  logic is_array;
  logic is_full;
  logic [2:0] min_bytes;
  fsg_pkg::fsg_op_t op_kind;
  fsg_pkg::fsg_region_t region;
  logic hit;
  logic wr_stat_go;
  logic array_go;
  logic nv_store_q;
  logic op_start_q;
  fsg_pkg::fsg_op_t op_kind_q;
  logic [23:0] op_addr_q;

  // Hold only pauses the link while the pins are not data lanes
  assign link_rst = cs_n_in | ~rstn_in;
  assign shift_en = snap_q[`FSG_BIT_QUAD] | io3_in;
  assign in_byte = {shift_q, io0_in};
  assign rd_cmd = (opcode_q == `FSG_CMD_RD_LO) ||
                  (opcode_q == `FSG_CMD_RD_HI);
  assign rd_byte = (opcode_q == `FSG_CMD_RD_LO) ? snap_q[7:0] :
                   snap_q[15:8];

  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      active_q <= 1'b0;
    end else if (shift_en) begin
      active_q <= 1'b1;
    end
  end

  // Frame fields are not cleared by chip select, so the system side can
  // read them after the frame ends; they stay until the next frame
  always_ff @(posedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_q <= 3'h0;
      bytes_q <= 3'h0;
      shift_q <= 7'h00;
      opcode_q <= `FSG_RST_BYTE;
      b1_q <= `FSG_RST_BYTE;
      b2_q <= `FSG_RST_BYTE;
      b3_q <= `FSG_RST_BYTE;
    end else if (shift_en) begin
      if (!active_q) begin
        bit_q <= 3'h1;
        bytes_q <= 3'h0;
        shift_q <= {6'h00, io0_in};
      end else begin
        bit_q <= bit_q + 3'h1;
        shift_q <= {shift_q[5:0], io0_in};
        if (bit_q == 3'h7) begin
          if (bytes_q != `FSG_LEN_MAX) begin
            bytes_q <= bytes_q + 3'h1;
          end
          unique case (bytes_q)
            3'h0: opcode_q <= in_byte;
            3'h1: b1_q <= in_byte;
            3'h2: b2_q <= in_byte;
            3'h3: b3_q <= in_byte;
            default: ;
          endcase
        end
      end
    end
  end

  // Status bytes shift out MSB first on the falling edge
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (shift_en && active_q && bytes_q != 3'h0 && rd_cmd) begin
      so_q <= rd_byte[~bit_q];
      so_oe_q <= 1'b1;
    end
  end

  assign io1_out = so_q;
  assign io1_oe_out = so_oe_q;

  // Pin synchronisers into the system clock
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_in;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= io2_in;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign frame_end = cs_s2_q & ~cs_s3_q;

  assign busy = (state_q == fsg_pkg::FSG_ST_STATUS) ||
                (state_q == fsg_pkg::FSG_ST_ARRAY);
  assign status_word = {
    state_q == fsg_pkg::FSG_ST_PAUSED,
    inv_q, 4'h0, quad_q, 1'b0, lock_q, guard_q, arm_q,
    busy
  };

  // Snapshot only moves while the link is idle; a read sees the
  // status as it stood when the frame began
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      snap_q <= 16'h0000;
    end else if (cs_s2_q) begin
      snap_q <= status_word;
    end
  end

  // Frame decode
  assign wp_eff = quad_q | wp_s2_q;
  assign stat_locked = lock_q & ~wp_eff;
  assign aligned = (bit_q == 3'h0) && (bytes_q != 3'h0);
  assign addr_m = {b1_q, b2_q, b3_q} &
                  (BIG_ARRAY ? `FSG_TOP_4M : `FSG_TOP_2M);
  assign region = guard_region(guard_q, inv_q, BIG_ARRAY);

  always_comb begin
    range_mask = `FSG_PAGE_MASK;
    op_kind = fsg_pkg::FSG_OP_PAGE;
    is_array = 1'b0;
    is_full = 1'b0;
    min_bytes = `FSG_LEN_PAGE;
    unique case (opcode_q)
      `FSG_CMD_PAGE: begin
        is_array = 1'b1;
      end
      `FSG_CMD_SECT: begin
        is_array = 1'b1;
        range_mask = `FSG_SECT_MASK;
        op_kind = fsg_pkg::FSG_OP_SECT;
        min_bytes = `FSG_LEN_ADDR;
      end
      `FSG_CMD_BLK32: begin
        is_array = 1'b1;
        range_mask = `FSG_B32_MASK;
        op_kind = fsg_pkg::FSG_OP_BLK32;
        min_bytes = `FSG_LEN_ADDR;
      end
      `FSG_CMD_BLK64: begin
        is_array = 1'b1;
        range_mask = `FSG_B64_MASK;
        op_kind = fsg_pkg::FSG_OP_BLK64;
        min_bytes = `FSG_LEN_ADDR;
      end
      `FSG_CMD_FULL_A, `FSG_CMD_FULL_B: begin
        is_full = 1'b1;
        op_kind = fsg_pkg::FSG_OP_FULL;
      end
      default: ;
    endcase
  end

  assign rstart = addr_m & ~range_mask;
  assign rend = rstart | range_mask;
  assign hit = region.en && region.lo <= rend && rstart <= region.hi;

  assign wr_stat_go = frame_end && aligned && loaded_q && arm_q &&
                      state_q == fsg_pkg::FSG_ST_IDLE && !stat_locked &&
                      opcode_q == `FSG_CMD_WR_STAT &&
                      (bytes_q == `FSG_LEN_STAT_SHORT ||
                       bytes_q == `FSG_LEN_STAT_LONG);

  assign array_go = frame_end && aligned && loaded_q && arm_q &&
                    state_q == fsg_pkg::FSG_ST_IDLE &&
                    ((is_array && bytes_q >= min_bytes && !hit) ||
                     (is_full && bytes_q == `FSG_LEN_CMD &&
                      !region.en));

  // Non-volatile bits: loaded once after reset, changed by status write
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loaded_q <= 1'b0;
      guard_q <= `FSG_RST_GUARD;
      lock_q <= 1'b0;
      quad_q <= 1'b0;
      inv_q <= 1'b0;
      nv_store_q <= 1'b0;
    end else begin
      nv_store_q <= wr_stat_go;
      if (!loaded_q) begin
        loaded_q <= 1'b1;
        {inv_q, quad_q, lock_q, guard_q} <= nv_bits_in;
      end else if (wr_stat_go) begin
        guard_q <= b1_q[`FSG_BIT_GUARD_HI:`FSG_BIT_GUARD_LO];
        lock_q <= b1_q[`FSG_BIT_LOCK];
        if (bytes_q == `FSG_LEN_STAT_LONG) begin
          quad_q <= b2_q[`FSG_BIT_QUAD - 8];
          inv_q <= b2_q[`FSG_BIT_INV - 8];
        end else begin
          quad_q <= 1'b0;
        end
      end
    end
  end

  // Write-arm latch; arm and disarm are ignored while a cycle runs
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arm_q <= 1'b0;
    end else if ((state_q == fsg_pkg::FSG_ST_STATUS &&
                  tw_cnt_q == 32'h0) ||
                 (state_q == fsg_pkg::FSG_ST_ARRAY && array_done_in)) begin
      arm_q <= 1'b0;
    end else if (frame_end && aligned && bytes_q == `FSG_LEN_CMD &&
                 state_q == fsg_pkg::FSG_ST_IDLE) begin
      if (opcode_q == `FSG_CMD_ARM) begin
        arm_q <= 1'b1;
      end else if (opcode_q == `FSG_CMD_DISARM) begin
        arm_q <= 1'b0;
      end
    end
  end

  // Busy sequencing: status cycle is self-timed, array ops end on done
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= fsg_pkg::FSG_ST_IDLE;
      tw_cnt_q <= 32'h0;
    end else begin
      unique case (state_q)
        fsg_pkg::FSG_ST_IDLE: begin
          if (wr_stat_go) begin
            state_q <= fsg_pkg::FSG_ST_STATUS;
            tw_cnt_q <= TW_CYCLES - 32'h1;
          end else if (array_go) begin
            state_q <= fsg_pkg::FSG_ST_ARRAY;
          end
        end
        fsg_pkg::FSG_ST_STATUS: begin
          if (tw_cnt_q == 32'h0) begin
            state_q <= fsg_pkg::FSG_ST_IDLE;
          end else begin
            tw_cnt_q <= tw_cnt_q - 32'h1;
          end
        end
        fsg_pkg::FSG_ST_ARRAY: begin
          if (array_done_in) begin
            state_q <= fsg_pkg::FSG_ST_IDLE;
          end else if (frame_end && aligned && bytes_q == `FSG_LEN_CMD &&
                       opcode_q == `FSG_CMD_SUSPEND) begin
            state_q <= fsg_pkg::FSG_ST_PAUSED;
          end
        end
        fsg_pkg::FSG_ST_PAUSED: begin
          if (frame_end && aligned && bytes_q == `FSG_LEN_CMD &&
              opcode_q == `FSG_CMD_RESUME) begin
            state_q <= fsg_pkg::FSG_ST_ARRAY;
          end
        end
        default: state_q <= fsg_pkg::FSG_ST_IDLE;
      endcase
    end
  end

  // Launch of an accepted array operation
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_start_q <= 1'b0;
      op_kind_q <= fsg_pkg::FSG_OP_PAGE;
      op_addr_q <= `FSG_RST_ADDR;
    end else begin
      op_start_q <= array_go;
      if (array_go) begin
        op_kind_q <= op_kind;
        op_addr_q <= addr_m;
      end
    end
  end

  assign op_start_out = op_start_q;
  assign op_kind_out = op_kind_q;
  assign op_addr_out = op_addr_q;
  assign op_suspend_out = (state_q == fsg_pkg::FSG_ST_PAUSED);
  assign nv_store_out = nv_store_q;
  assign nv_bits_out = {inv_q, quad_q, lock_q, guard_q};
  assign status_out = status_word;
  assign quad_mode_out = quad_q;

endmodule
`default_nettype wire

// file: fsg_defs.svh
`ifndef FSG_DEFS_SVH
`define FSG_DEFS_SVH

// Command opcodes
`define FSG_CMD_ARM 8'h06
`define FSG_CMD_DISARM 8'h04
`define FSG_CMD_RD_LO 8'h05
`define FSG_CMD_RD_HI 8'h35
`define FSG_CMD_WR_STAT 8'h01
`define FSG_CMD_PAGE 8'h02
`define FSG_CMD_SECT 8'h20
`define FSG_CMD_BLK32 8'h52
`define FSG_CMD_BLK64 8'hd8
`define FSG_CMD_FULL_A 8'hc7
`define FSG_CMD_FULL_B 8'h60
`define FSG_CMD_SUSPEND 8'h75
`define FSG_CMD_RESUME 8'h7a

// Status word bit positions
`define FSG_BIT_BUSY 0
`define FSG_BIT_ARM 1
`define FSG_BIT_GUARD_LO 2
`define FSG_BIT_GUARD_HI 6
`define FSG_BIT_LOCK 7
`define FSG_BIT_QUAD 9
`define FSG_BIT_INV 14
`define FSG_BIT_SUSP 15

// Reset values of the volatile bits and non-volatile defaults
`define FSG_RST_GUARD 5'h00
`define FSG_RST_BYTE 8'h00
`define FSG_RST_ADDR 24'h000000

// Array geometry
`define FSG_TOP_4M 24'h07ffff
`define FSG_TOP_2M 24'h03ffff
`define FSG_BLOCK_64K 24'h010000
`define FSG_SECT_4K 24'h001000
`define FSG_PAGE_MASK 24'h0000ff
`define FSG_SECT_MASK 24'h000fff
`define FSG_B32_MASK 24'h007fff
`define FSG_B64_MASK 24'h00ffff

// Frame lengths in bytes, opcode included
`define FSG_LEN_CMD 3'h1
`define FSG_LEN_STAT_SHORT 3'h2
`define FSG_LEN_STAT_LONG 3'h3
`define FSG_LEN_ADDR 3'h4
`define FSG_LEN_PAGE 3'h5
`define FSG_LEN_MAX 3'h7

// Timing
`define FSG_CLK_NS 10
`define FSG_TW_NS 5000000
`define FSG_TW_CYCLES (`FSG_TW_NS / `FSG_CLK_NS)

`endif

// file: fsg_pkg.sv
package fsg_pkg;

  typedef enum logic [3:0] {
    FSG_ST_IDLE = 4'b0001,
    FSG_ST_STATUS = 4'b0010,
    FSG_ST_ARRAY = 4'b0100,
    FSG_ST_PAUSED = 4'b1000
  } fsg_state_t;

  typedef enum logic [2:0] {
    FSG_OP_PAGE = 3'h0,
    FSG_OP_SECT = 3'h1,
    FSG_OP_BLK32 = 3'h2,
    FSG_OP_BLK64 = 3'h3,
    FSG_OP_FULL = 3'h4
  } fsg_op_t;

  typedef struct packed {
    logic en;
    logic [23:0] lo;
    logic [23:0] hi;
  } fsg_region_t;

endpackage

// file: fsg_flash_guard_props.sv
`timescale 1ns/10ps
`default_nettype none
module fsg_flash_guard_props #(
  parameter bit BIG_ARRAY = 1'b1,
  parameter int unsigned TW_CYCLES = 10
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Pins, non-volatile storage and array engine
  input wire logic io2_in,
  input wire logic array_done_in,
  input wire logic [7:0] nv_bits_out,
  input wire logic nv_store_out,
  input wire logic op_start_out,
  input wire fsg_pkg::fsg_op_t op_kind_out,
  input wire logic op_suspend_out,
  // Status view
  input wire logic [15:0] status_out,
  input wire logic quad_mode_out
);
  localparam int TW_HI = TW_CYCLES + 1;
  logic [4:0] bp_w;
  logic none_w;
  logic [3:0] low_cnt_q;
  assign bp_w = status_out[6:2];
  always_comb begin
    if (BIG_ARRAY) begin
      none_w = status_out[14] ? (bp_w[2] && (!bp_w[4] || &bp_w[1:0]))
                              : ~|bp_w[2:0];
    end else if (status_out[14]) begin
      none_w = bp_w[4] ? &bp_w[2:0] : &bp_w[1:0];
    end else begin
      none_w = bp_w[4] ? ~|bp_w[2:0] : ~|bp_w[1:0];
    end
  end
  // Saturates so a long low spell never wraps back to looking fresh
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_cnt_q <= 4'h0;
    end else if (io2_in) begin
      low_cnt_q <= 4'h0;
    end else if (low_cnt_q != 4'hf) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence wr_busy;
    (status_out[1:0] == 2'h3) [*6];
  endsequence
  sequence wr_idle;
    status_out[1:0] == 2'h0;
  endsequence
  busy_start_a: assert property (
    op_start_out |-> status_out[1:0] == 2'h3)
    else $error("array op started without busy and arm");
  arm_gate_a: assert property (
    $rose(status_out[0]) |-> $past(status_out[1]))
    else $error("busy rose while arm latch was clear");
  wr_cycle_a: assert property (
    nv_store_out |-> wr_busy ##[1:TW_HI] wr_idle)
    else $error("status write cycle length or arm clear wrong");
  done_clear_a: assert property (
    array_done_in && status_out[0] && !op_suspend_out |=>
      status_out[1:0] == 2'h0)
    else $error("completion did not clear busy and arm");
  full_wipe_a: assert property (
    op_start_out && op_kind_out == fsg_pkg::FSG_OP_FULL |-> none_w)
    else $error("whole array erase started with a guarded region");
  guard_lock_a: assert property (
    $changed(bp_w) && $past(status_out[7]) && !$past(quad_mode_out)
      |-> $past(low_cnt_q) < 4'h8)
    else $error("guard bits changed under hardware lock");
  susp_view_a: assert property (
    op_suspend_out |-> status_out[15] && !status_out[0])
    else $error("suspend state not shown in status");
  resume_busy_a: assert property (
    $fell(status_out[15]) |-> status_out[0])
    else $error("resume did not restore busy");
  reserved_zero_a: assert property (
    status_out[13:10] == 4'h0 && !status_out[8])
    else $error("reserved status bits not zero");
  nv_mirror_a: assert property (
    nv_store_out |-> nv_bits_out ==
      {status_out[14], status_out[9], status_out[7:2]})
    else $error("stored bits differ from status word");
endmodule
bind fsg_flash_guard fsg_flash_guard_props #(
  .BIG_ARRAY(BIG_ARRAY),
  .TW_CYCLES(TW_CYCLES)
) props (
  .mclk_in(mclk_in),
  .rstn_in(rstn_in),
  .io2_in(io2_in),
  .array_done_in(array_done_in),
  .nv_bits_out(nv_bits_out),
  .nv_store_out(nv_store_out),
  .op_start_out(op_start_out),
  .op_kind_out(op_kind_out),
  .op_suspend_out(op_suspend_out),
  .status_out(status_out),
  .quad_mode_out(quad_mode_out)
);
`default_nettype wire

// file: fsg_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
module fsg_spi_host (
  // Link pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic io0_out,
  input wire logic io1_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io0_out = 1'b0;
  end
  // Mode 0: clock parked low, runs only inside a frame
  task automatic frame(input logic [39:0] d, input int nb, input bit rd,
                       output logic [7:0] q);
    q = 8'h00;
    cs_n_out = 1'b0;
    for (int i = 0; i < nb * 8 + (rd ? 8 : 0); i++) begin
      io0_out = (i < nb * 8) ? d[39 - i] : ~io0_out;
      #62.5 sclk_out = 1'b1;
      if (i >= nb * 8) q = {q[6:0], io1_in};
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    // Released line flips so a stale bit cannot look valid
    io0_out = ~io0_out;
    #400;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_top;
  typedef struct {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] op;
    logic [23:0] a;
    logic ok;
    logic [2:0] k;
  } fsg_case_t;
  localparam logic [39:0] arm_frame = 40'h0600000000;
  logic mclk = 1'b0;
  logic rstn, io2, io3, done;
  logic [7:0] nv_bits, rq;
  wire sclk, cs_n, io0, io1, io1_oe, nv_store, op_start, susp_out, quad;
  wire [7:0] nv_out;
  wire [23:0] op_addr;
  wire [15:0] status;
  fsg_pkg::fsg_op_t op_kind, last_kind;
  logic [23:0] last_addr;
  int fail_count = 0;
  int total_checks = 0;
  int starts = 0;
  fsg_case_t cases [14] = '{
    '{8'h04, 8'h00, 8'h20, 24'h07f000, 1'b0, 3'h1},
    '{8'h04, 8'h00, 8'h20, 24'h06f000, 1'b1, 3'h1},
    '{8'h04, 8'h00, 8'h52, 24'h068000, 1'b1, 3'h2},
    '{8'h04, 8'h00, 8'h52, 24'h078000, 1'b0, 3'h2},
    '{8'h04, 8'h40, 8'h20, 24'h070000, 1'b1, 3'h1},
    '{8'h04, 8'h40, 8'h20, 24'h06f000, 1'b0, 3'h1},
    '{8'h28, 8'h40, 8'h20, 24'h01f000, 1'b1, 3'h1},
    '{8'h28, 8'h40, 8'hd8, 24'h020000, 1'b0, 3'h3},
    '{8'h44, 8'h40, 8'h20, 24'h07f000, 1'b1, 3'h1},
    '{8'h44, 8'h40, 8'h02, 24'h07ef00, 1'b0, 3'h0},
    '{8'h64, 8'h40, 8'hd8, 24'h000000, 1'b0, 3'h3},
    '{8'h64, 8'h40, 8'h20, 24'h000000, 1'b1, 3'h1},
    '{8'h00, 8'h00, 8'hc7, 24'h000000, 1'b1, 3'h4},
    '{8'h0c, 8'h00, 8'h60, 24'h000000, 1'b0, 3'h4}
  };
  always #5 mclk = ~mclk;
  fsg_flash_guard #(.BIG_ARRAY(1'b1), .TW_CYCLES(10)) uut (
    .mclk_in(mclk), .rstn_in(rstn), .sclk_in(sclk), .cs_n_in(cs_n),
    .io0_in(io0), .io1_out(io1), .io1_oe_out(io1_oe), .io2_in(io2),
    .io3_in(io3), .nv_bits_in(nv_bits), .nv_bits_out(nv_out),
    .nv_store_out(nv_store), .op_start_out(op_start),
    .op_kind_out(op_kind), .op_addr_out(op_addr),
    .op_suspend_out(susp_out), .array_done_in(done),
    .status_out(status), .quad_mode_out(quad));
  fsg_spi_host host (.sclk_out(sclk), .cs_n_out(cs_n), .io0_out(io0),
    .io1_in(io1));
  // Mid-cycle sampling keeps the capture clear of the launch edge
  always @(negedge mclk) begin
    if (op_start === 1'b1) begin
      starts++;
      last_kind = op_kind;
      last_addr = op_addr;
    end
  end
  task automatic cmd(input logic [39:0] d, input int nb);
    host.frame(d, nb, 1'b0, rq);
  endtask
  task automatic wstat(input logic [7:0] b1, input logic [7:0] b2);
    cmd(arm_frame, 1);
    cmd({8'h01, b1, b2, 16'h0000}, 3);
  endtask
  task automatic pulse_done;
    @(posedge mclk);
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic run(input fsg_case_t c);
    int n0;
    int nb;
    n0 = starts;
    nb = (c.op == 8'h02) ? 5 : ((c.k == 3'h4) ? 1 : 4);
    wstat(c.s1, c.s2);
    `CHK("guard", {c.s2[6], c.s1[6:2]}, {status[14], status[6:2]})
    cmd(arm_frame, 1);
    cmd({c.op, c.a, 8'h5a}, nb);
    `CHK("started", c.ok, starts != n0)
    if (c.ok) begin
      `CHK("kind", c.k, last_kind)
      if (c.k != 3'h4) `CHK("addr", c.a, last_addr)
      `CHK("busy", 1'b1, status[0])
      pulse_done;
      `CHK("arm after done", 2'h0, status[1:0])
    end else begin
      `CHK("arm kept", 2'h2, status[1:0])
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #900000;
    fail_count++;
    give_verdict;
  end
  initial begin
    rstn = 1'b0;
    io2 = 1'b1;
    io3 = 1'b1;
    done = 1'b0;
    nv_bits = 8'h00;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK("reset word", 16'h0000, status)
    cmd({8'h20, 24'h010000, 8'h00}, 4);
    `CHK("unarmed erase", 0, starts)
    cmd(arm_frame, 1);
    host.frame({8'h05, 32'h0}, 1, 1'b1, rq);
    `CHK("read armed", 8'h02, rq)
    `CHK("oe released", 1'b0, io1_oe)
    cmd(40'h0400000000, 1);
    `CHK("disarmed", 2'h0, status[1:0])
    wstat(8'h07, 8'hbc);
    `CHK("kept bits", 16'h0004, status)
    foreach (cases[i]) run(cases[i]);
    wstat(8'h00, 8'h00);
    cmd(arm_frame, 1);
    cmd({8'h20, 24'h010000, 8'h00}, 4);
    cmd(40'h7500000000, 1);
    `CHK("suspended", 3'h5, {status[15], status[0], susp_out})
    host.frame({8'h35, 32'h0}, 1, 1'b1, rq);
    `CHK("read high", 8'h80, rq)
    cmd(40'h7a00000000, 1);
    `CHK("resumed", 2'h1, {status[15], status[0]})
    pulse_done;
    wstat(8'h84, 8'h00);
    @(posedge mclk);
    io2 <= 1'b0;
    wstat(8'h80, 8'h00);
    `CHK("locked", 6'h21, status[7:2])
    @(posedge mclk);
    io2 <= 1'b1;
    wstat(8'h00, 8'h00);
    `CHK("unlocked", 6'h00, status[7:2])
    // Protect and hold lines are driven, never strapped, before quad
    wstat(8'h00, 8'h02);
    `CHK("quad on", 1'b1, quad)
    `CHK("stored bits", 8'h40, nv_out)
    cmd(arm_frame, 1);
    cmd({8'h01, 8'h00, 24'h000000}, 2);
    `CHK("quad cleared", 1'b0, quad)
    give_verdict;
  end
endmodule
`default_nettype wire
